/* rtl/scfr_pkg.sv */
// Package for the stage-one context fault register bank: offsets, fields, reset values, types.
package scfr_pkg;

	// Register byte offsets (chosen locally, one aligned word each)
	localparam logic [7:0] OFF_AUX_CONTROL = 8'h00;
	localparam logic [7:0] OFF_REQ_PR_LO = 8'h10;
	localparam logic [7:0] OFF_REQ_PR_HI = 8'h14;
	localparam logic [7:0] OFF_REQ_UR_LO = 8'h18;
	localparam logic [7:0] OFF_REQ_UR_HI = 8'h1c;
	localparam logic [7:0] OFF_REQ_UW_LO = 8'h20;
	localparam logic [7:0] OFF_REQ_UW_HI = 8'h24;
	localparam logic [7:0] OFF_XLATE_STATUS = 8'h28;
	localparam logic [7:0] OFF_CONTEXT_ID = 8'h30;
	localparam logic [7:0] OFF_FAULT_ADDR_LO = 8'h40;
	localparam logic [7:0] OFF_FAULT_ADDR_HI = 8'h44;
	localparam logic [7:0] OFF_FAULT_STATUS = 8'h48;
	localparam logic [7:0] OFF_FAULT_RELOAD = 8'h4c;
	localparam logic [7:0] OFF_CONFIG = 8'h50;

	// Fault address width: implemented low bits of the fault address
	localparam int FAR_BITS = 48;
	// Request address field starts at bit 12
	localparam int REQ_ADDR_LSB = 12;

	// Fault status field positions
	localparam int FS_MULTI = 31;
	localparam int FS_STALLED = 30;
	localparam int FS_FMT_HI = 10;
	localparam int FS_FMT_LO = 9;
	localparam int FS_UUT = 8;
	localparam int FS_FLAG_LO = 1;

	// Writable fault flags (bits 8..1) plus multi bit
	localparam logic [31:0] FS_W1C_MASK = 32'h8000_01fe;

	// Scheme encodings
	localparam logic [1:0] FMT_SHORT32 = 2'h0;
	localparam logic [1:0] FMT_LONG32 = 2'h1;
	localparam logic [1:0] FMT_WIDE64 = 2'h2;

	// Reset values
	localparam logic [31:0] RST_XLATE_STATUS = 32'h0000_0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Translation cycle count; not used, a translation ends when XDONE_I is seen
	localparam logic [3:0] XLATE_CYCLES = 4'h4;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Translation request kinds
	typedef enum logic [1:0] {
		REQ_PRIV_READ = 2'b00,
		REQ_UNPRIV_READ = 2'b01,
		REQ_UNPRIV_WRITE = 2'b10
	} scfr_req_kind_t;

	// Translator states
	typedef enum logic [0:0] {
		XS_IDLE = 1'b0,
		XS_BUSY = 1'b1
	} scfr_xstate_t;

	// Fault report from the walker
	typedef struct packed {
		logic valid;
		logic stall;
		logic [7:0] flags;
		logic [FAR_BITS-1:0] addr;
	} scfr_fault_t;

	// Translation request to the walker
	typedef struct packed {
		logic valid;
		scfr_req_kind_t kind;
		logic [63:0] addr;
	} scfr_xreq_t;

endpackage : scfr_pkg

/* rtl/scfr_regs.sv */
// Stage-one context register bank with AXI4-Lite slave, translation request and fault status logic.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module scfr_regs (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output scfr_pkg::scfr_xreq_t XREQ_O,
	input wire logic XDONE_I,
	input wire scfr_pkg::scfr_fault_t FAULT_I,
	input wire logic RESUME_WR_I,
	input wire logic RETRY_EVENT_I,
	input wire logic WIDE_SELECT_I,
	output logic STALLED_O,
	output logic [7:0] ADDR_SPACE_TAG_O,
	output logic TAG_FROM_TABLE_O,
	output logic [31:0] AUX_CONTROL_O
);
	import scfr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Write channel capture: address and data accepted in either order
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wr_fire;

	assign S_AXI_AWREADY_O = !aw_have_q && !bvalid_q;
	assign S_AXI_WREADY_O = !w_have_q && !bvalid_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O = bresp_q;

	// Hold each half until both are present
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR_I;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_have_q <= 1'b1;
				w_data_q <= S_AXI_WDATA_I;
				w_strb_q <= S_AXI_WSTRB_I;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Known word addresses answer OKAY, the rest SLVERR
	function automatic logic addr_known(input logic [7:0] a);
		case (a)
			OFF_AUX_CONTROL, OFF_REQ_PR_LO, OFF_REQ_PR_HI, OFF_REQ_UR_LO, OFF_REQ_UR_HI,
			OFF_REQ_UW_LO, OFF_REQ_UW_HI, OFF_XLATE_STATUS, OFF_CONTEXT_ID, OFF_FAULT_ADDR_LO,
			OFF_FAULT_ADDR_HI, OFF_FAULT_STATUS, OFF_FAULT_RELOAD, OFF_CONFIG: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction : addr_known

	// Byte-lane merge used by the auxiliary control, identifier and fault address registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// Write response
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY_I) begin
			bvalid_q <= 1'b0;
		end
	end

	logic wr_aux;
	logic wr_cid;
	logic wr_far_lo;
	logic wr_far_hi;
	logic wr_fs;
	logic wr_reload;
	logic wr_cfg;
	assign wr_aux = wr_fire && aw_addr_q == OFF_AUX_CONTROL;
	assign wr_cid = wr_fire && aw_addr_q == OFF_CONTEXT_ID;
	assign wr_far_lo = wr_fire && aw_addr_q == OFF_FAULT_ADDR_LO;
	assign wr_far_hi = wr_fire && aw_addr_q == OFF_FAULT_ADDR_HI;
	assign wr_fs = wr_fire && aw_addr_q == OFF_FAULT_STATUS;
	assign wr_reload = wr_fire && aw_addr_q == OFF_FAULT_RELOAD;
	assign wr_cfg = wr_fire && aw_addr_q == OFF_CONFIG;

	////////////////////////////////////////////////////////////////////////
	// Plain storage: auxiliary control, identifier, configuration
	logic [31:0] aux_q;
	logic [31:0] cid_q;
	logic ext_en_q;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			aux_q <= RST_WORD;
			cid_q <= RST_WORD;
			ext_en_q <= 1'b0;
		end else begin
			if (wr_aux) begin
				aux_q <= merge(aux_q, w_data_q, w_strb_q);
			end
			if (wr_cid) begin
				cid_q <= merge(cid_q, w_data_q, w_strb_q);
			end
			if (wr_cfg && w_strb_q[0]) begin
				ext_en_q <= w_data_q[0];
			end
		end
	end

	// Tag driven from the identifier whenever ext_en_q is clear, in wide format too; process tag never drives hardware
	assign ADDR_SPACE_TAG_O = ext_en_q ? 8'h00 : cid_q[7:0];
	assign TAG_FROM_TABLE_O = ext_en_q;
	assign AUX_CONTROL_O = aux_q;

	////////////////////////////////////////////////////////////////////////
	// Translation requests: low word starts a zero-extended request
	logic req_hit;
	scfr_req_kind_t req_kind;
	scfr_xstate_t xstate_q;
	scfr_xreq_t xreq_q;

	always_comb begin
		req_hit = 1'b0;
		req_kind = REQ_PRIV_READ;
		case (aw_addr_q)
			OFF_REQ_PR_LO: begin
				req_hit = wr_fire;
				req_kind = REQ_PRIV_READ;
			end
			OFF_REQ_UR_LO: begin
				req_hit = wr_fire;
				req_kind = REQ_UNPRIV_READ;
			end
			OFF_REQ_UW_LO: begin
				req_hit = wr_fire;
				req_kind = REQ_UNPRIV_WRITE;
			end
			default: req_hit = 1'b0;
		endcase
	end

	// A request during a busy translation is dropped so the pending result stays coherent
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			xstate_q <= XS_IDLE;
			xreq_q <= '0;
		end else begin
			case (xstate_q)
				XS_IDLE: begin
					xreq_q.valid <= 1'b0;
					if (req_hit) begin
						xstate_q <= XS_BUSY;
						xreq_q.valid <= 1'b1;
						xreq_q.kind <= req_kind;
						xreq_q.addr <= {32'h0000_0000, w_data_q[31:REQ_ADDR_LSB], 12'h000};
					end
				end
				XS_BUSY: begin
					xreq_q.valid <= 1'b0;
					if (XDONE_I) begin
						xstate_q <= XS_IDLE;
					end
				end
				default: xstate_q <= XS_IDLE;
			endcase
		end
	end

	assign XREQ_O = xreq_q;

	////////////////////////////////////////////////////////////////////////
	// Fault address: raw input address, low bits kept exactly
	logic [FAR_BITS-1:0] far_q;
	logic [63:0] far_wide;
	logic [31:0] far_hi_merged;
	assign far_wide = {{(64-FAR_BITS){1'b0}}, far_q};
	// Upper word merged at full width first; only the implemented bits are kept
	assign far_hi_merged = merge({16'h0000, far_q[FAR_BITS-1:32]}, w_data_q, w_strb_q);

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			far_q <= '0;
		end else if (FAULT_I.valid) begin
			far_q <= FAULT_I.addr;
		end else if (wr_far_lo) begin
			far_q[31:0] <= merge(far_q[31:0], w_data_q, w_strb_q);
		end else if (wr_far_hi) begin
			far_q[FAR_BITS-1:32] <= far_hi_merged[FAR_BITS-33:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault status: sticky flags, set wins over a same-cycle clear
	logic [31:0] fs_q;
	logic stalled_q;
	logic [1:0] fmt;
	logic [31:0] fs_rd;

	assign fmt = WIDE_SELECT_I ? FMT_WIDE64 : (ext_en_q ? FMT_LONG32 : FMT_SHORT32);

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			fs_q <= RST_WORD;
		end else begin
			if (wr_fs) begin
				fs_q <= fs_q & ~(w_data_q & FS_W1C_MASK);
			end else if (wr_reload) begin
				fs_q <= w_data_q & FS_W1C_MASK;
			end
			if (FAULT_I.valid) begin
				fs_q[FS_UUT:FS_FLAG_LO] <= (wr_fs ? fs_q[FS_UUT:FS_FLAG_LO] & ~w_data_q[FS_UUT:FS_FLAG_LO]
					: fs_q[FS_UUT:FS_FLAG_LO]) | FAULT_I.flags;
				fs_q[FS_MULTI] <= fs_q[FS_MULTI] | (fs_rd != 32'h0000_0000);
			end
		end
	end

	// Stall flag: only resume or an optional retry event releases it
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			stalled_q <= 1'b0;
		end else if (FAULT_I.valid && FAULT_I.stall) begin
			stalled_q <= 1'b1;
		end else if (RESUME_WR_I || RETRY_EVENT_I) begin
			stalled_q <= 1'b0;
		end
	end

	assign fs_rd = {fs_q[FS_MULTI], stalled_q, 19'h0_0000, fmt, fs_q[FS_UUT:FS_FLAG_LO], 1'b0};
	assign STALLED_O = stalled_q;

	////////////////////////////////////////////////////////////////////////
	// Read channel
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	assign S_AXI_ARREADY_O = !rvalid_q;
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RDATA_O = rdata_q;
	assign S_AXI_RRESP_O = rresp_q;

	// Request registers and the reload register read as zero
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (S_AXI_ARVALID_I && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q <= addr_known(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
			case (S_AXI_ARADDR_I)
				OFF_AUX_CONTROL: rdata_q <= aux_q;
				OFF_XLATE_STATUS: rdata_q <= {31'h0000_0000, xstate_q == XS_BUSY};
				OFF_CONTEXT_ID: rdata_q <= cid_q;
				OFF_FAULT_ADDR_LO: rdata_q <= far_wide[31:0];
				OFF_FAULT_ADDR_HI: rdata_q <= far_wide[63:32];
				OFF_FAULT_STATUS: rdata_q <= fs_rd;
				OFF_CONFIG: rdata_q <= {31'h0000_0000, ext_en_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else if (S_AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_req_starts_busy: assert property (@(posedge CLK_I) disable iff (RST_I)
		(xstate_q == XS_IDLE && req_hit) |=> (xstate_q == XS_BUSY && XREQ_O.valid))
		else $error("request did not start translation");
	a_done_ends_busy: assert property (@(posedge CLK_I) disable iff (RST_I)
		(xstate_q == XS_BUSY && XDONE_I) |=> xstate_q == XS_IDLE)
		else $error("active bit stuck after result");
	a_hi_word_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
		(xstate_q == XS_IDLE && wr_fire && aw_addr_q == OFF_REQ_PR_HI) |=> !XREQ_O.valid)
		else $error("upper word write started translation");
	a_req_zero_ext: assert property (@(posedge CLK_I) disable iff (RST_I)
		XREQ_O.valid |-> (XREQ_O.addr[63:32] == 32'h0000_0000 && XREQ_O.addr[11:0] == 12'h000))
		else $error("request address not zero extended");
	a_stall_holds: assert property (@(posedge CLK_I) disable iff (RST_I)
		(stalled_q && !RESUME_WR_I && !RETRY_EVENT_I) |=> stalled_q)
		else $error("stall cleared without resume");
	a_reload_keeps_ss: assert property (@(posedge CLK_I) disable iff (RST_I)
		(wr_reload && !FAULT_I.valid && !RESUME_WR_I && !RETRY_EVENT_I) |=> $stable(stalled_q))
		else $error("reload changed stalled bit");
	a_multi_sets: assert property (@(posedge CLK_I) disable iff (RST_I)
		(FAULT_I.valid && fs_rd != 32'h0000_0000) |=> fs_q[FS_MULTI])
		else $error("multi bit not set");
	a_fault_sets_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
		FAULT_I.valid |=> ((fs_q[FS_UUT:FS_FLAG_LO] & $past(FAULT_I.flags)) == $past(FAULT_I.flags)))
		else $error("fault flag lost");
	a_w1c_clears: assert property (@(posedge CLK_I) disable iff (RST_I)
		(wr_fs && !FAULT_I.valid && w_data_q[FS_FLAG_LO]) |=> !fs_q[FS_FLAG_LO])
		else $error("write one did not clear");
	a_fmt_field: assert property (@(posedge CLK_I) disable iff (RST_I)
		fs_rd[FS_FMT_HI:FS_FMT_LO] == (WIDE_SELECT_I ? 2'h2 : {1'b0, ext_en_q}))
		else $error("scheme field wrong");
	a_far_raw_capture: assert property (@(posedge CLK_I) disable iff (RST_I)
		FAULT_I.valid |=> far_q == $past(FAULT_I.addr))
		else $error("fault address not captured raw");
	a_reload_loads: assert property (@(posedge CLK_I) disable iff (RST_I)
		(wr_reload && !FAULT_I.valid) |=> (fs_q & FS_W1C_MASK) == $past(w_data_q & FS_W1C_MASK))
		else $error("reload value not loaded");

endmodule : scfr_regs

/* sim/tb_top.sv */
// Self-checking bench for the stage-one context register bank over AXI4-Lite.
`timescale 1ns/1ps
module tb_top;
	import scfr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awa = 8'h00, ara = 8'h00, a;
	logic awv = 1'b0, wv = 1'b0, arv = 1'b0, xd = 1'b0, rsm = 1'b0, rty = 1'b0, wide = 1'b0;
	logic [31:0] wd = 32'h0, r, seed = 32'h0000_894d;
	logic [47:0] fa;
	scfr_fault_t flt = '0;
	scfr_xreq_t xr;
	logic awr, wr, bv, arr, rv, stl, tft;
	logic [1:0] br, rr;
	logic [31:0] rdat, aux;
	logic [7:0] ast;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [53:0] xq[$];
	int n_errors = 0;
	int check_count = 0;

	////////////////////////////////////////////////////////////////
	// Clock and design
	always #5 clk = ~clk;

	scfr_regs dut (.CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
		.S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .XREQ_O(xr), .XDONE_I(xd),
		.FAULT_I(flt), .RESUME_WR_I(rsm), .RETRY_EVENT_I(rty), .WIDE_SELECT_I(wide), .STALLED_O(stl),
		.ADDR_SPACE_TAG_O(ast), .TAG_FROM_TABLE_O(tft), .AUX_CONTROL_O(aux));

	////////////////////////////////////////////////////////////////
	// Helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task chk(input logic [63:0] s, input logic [63:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// Write: offer both channels, drop each once taken, then wait for the response
	task automatic wr32(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
		int t;
		logic da, dw;
		bq.push_back(e);
		da = 1'b0;
		dw = 1'b0;
		t = 0;
		@(posedge clk);
		awa <= ad;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(da && dw) && t < 40) begin
			@(negedge clk);
			if (awv && awr) da = 1'b1;
			if (wv && wr) dw = 1'b1;
			@(posedge clk);
			if (da) awv <= 1'b0;
			if (dw) wv <= 1'b0;
			t++;
		end
		t = 0;
		do begin @(negedge clk); t++; end while (bv !== 1'b1 && t < 40);
		@(posedge clk);
	endtask : wr32

	task automatic rd32(input logic [7:0] ad, input logic [33:0] e);
		int t;
		rq.push_back(e);
		t = 0;
		@(posedge clk);
		ara <= ad;
		arv <= 1'b1;
		do begin @(negedge clk); t++; end while (arr !== 1'b1 && t < 40);
		@(posedge clk);
		arv <= 1'b0;
		t = 0;
		do begin @(negedge clk); t++; end while (rv !== 1'b1 && t < 40);
		@(posedge clk);
	endtask : rd32

	// One-cycle fault report from the walker
	task fault(input logic s, input logic [7:0] f);
		@(posedge clk);
		flt <= '{1'b1, s, f, fa};
		@(posedge clk);
		flt.valid <= 1'b0;
	endtask : fault

	////////////////////////////////////////////////////////////////
	// Monitor: each result that appears is matched against the oldest note
	always @(negedge clk) begin
		if (rst === 1'b0) begin
			if (rv === 1'b1) begin
				if (rq.size() == 0) chk(1, 0);
				else chk({rr, rdat}, rq.pop_front());
			end
			if (bv === 1'b1) begin
				if (bq.size() == 0) chk(1, 0);
				else chk(br, bq.pop_front());
			end
			if (xr.valid === 1'b1) begin
				if (xq.size() == 0) chk(1, 0);
				else chk({xr.kind, xr.addr[63:12]}, xq.pop_front());
			end
		end
	end

	task summarize();
		if (rq.size() + bq.size() + xq.size() != 0) n_errors++;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize

	// Watchdog: whole run needs a few hundred cycles
	initial begin
		#100us;
		n_errors++;
		summarize();
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd32(OFF_XLATE_STATUS, 34'h0);
		rd32(OFF_FAULT_STATUS, 34'h0);
		rd32(8'h60, {RESP_SLVERR, 32'h0});
		wr32(8'h60, 32'h1, RESP_SLVERR);
		wr32(OFF_XLATE_STATUS, 32'hffff_ffff, RESP_OKAY);
		rd32(OFF_XLATE_STATUS, 34'h0);
		$display("test reset and map done");
		r = rnd();
		wr32(OFF_AUX_CONTROL, r, RESP_OKAY);
		rd32(OFF_AUX_CONTROL, {2'h0, r});
		@(negedge clk) chk(aux, r);
		r = rnd();
		wr32(OFF_CONTEXT_ID, r, RESP_OKAY);
		@(negedge clk) chk(ast, r[7:0]);
		wr32(OFF_CONFIG, 32'h1, RESP_OKAY);
		@(negedge clk) chk({tft, ast}, {1'b1, 8'h00});
		rd32(OFF_CONTEXT_ID, {2'h0, r});
		rd32(OFF_FAULT_STATUS, 34'h200);
		wide <= 1'b1;
		rd32(OFF_FAULT_STATUS, 34'h400);
		wide <= 1'b0;
		wr32(OFF_CONFIG, 32'h0, RESP_OKAY);
		$display("test identifier and scheme done");
		// Each request kind, then an upper-word write while idle must start nothing
		for (int k = 0; k < 3; k++) begin
			a = OFF_REQ_PR_LO + 8'(8 * k);
			r = rnd();
			xq.push_back({k[1:0], 32'h0, r[31:12]});
			wr32(a, r, RESP_OKAY);
			rd32(OFF_XLATE_STATUS, 34'h1);
			@(posedge clk) xd <= 1'b1;
			@(posedge clk) xd <= 1'b0;
			rd32(OFF_XLATE_STATUS, 34'h0);
			wr32(a + 8'h04, rnd(), RESP_OKAY);
			rd32(a + 8'h04, 34'h0);
		end
		$display("test requests done");
		r = rnd();
		fa = {r[15:0], rnd()};
		fault(1'b1, 8'h01);
		rd32(OFF_FAULT_STATUS, 34'h4000_0002);
		@(negedge clk) chk(stl, 1'b1);
		rd32(OFF_FAULT_ADDR_LO, {2'h0, fa[31:0]});
		rd32(OFF_FAULT_ADDR_HI, {18'h0, fa[47:32]});
		fault(1'b0, 8'h04);
		rd32(OFF_FAULT_STATUS, 34'hc000_000a);
		wr32(OFF_FAULT_STATUS, 32'h4000_0003, RESP_OKAY);
		rd32(OFF_FAULT_STATUS, 34'hc000_0008);
		wr32(OFF_FAULT_RELOAD, 32'h0000_07ff, RESP_OKAY);
		rd32(OFF_FAULT_STATUS, 34'h4000_01fe);
		rd32(OFF_FAULT_RELOAD, 34'h0);
		@(posedge clk) rsm <= 1'b1;
		@(posedge clk) rsm <= 1'b0;
		rd32(OFF_FAULT_STATUS, 34'h0000_01fe);
		@(negedge clk) chk(stl, 1'b0);
		fault(1'b1, 8'h80);
		rd32(OFF_FAULT_STATUS, 34'hc000_01fe);
		@(posedge clk) rty <= 1'b1;
		@(posedge clk) rty <= 1'b0;
		rd32(OFF_FAULT_STATUS, 34'h8000_01fe);
		wr32(OFF_FAULT_STATUS, 32'hffff_ffff, RESP_OKAY);
		rd32(OFF_FAULT_STATUS, 34'h0);
		// Every flag lands at its own bit, one above its walker index
		for (int i = 0; i < 8; i++) begin
			fault(1'b0, 8'(1 << i));
			rd32(OFF_FAULT_STATUS, 34'(1 << (i + 1)));
			wr32(OFF_FAULT_STATUS, 32'hffff_ffff, RESP_OKAY);
		end
		wr32(OFF_FAULT_ADDR_HI, 32'hffff_ffff, RESP_OKAY);
		rd32(OFF_FAULT_ADDR_HI, 34'h0000_ffff);
		$display("test faults done");
		summarize();
	end
endmodule : tb_top
